/* include/tacsc_pkg.sv */
// constants and types shared by the converter serial control block
package tacsc_pkg;
	// ----------------------------------------------------------------
	// widths and timing
	// ----------------------------------------------------------------
	localparam int          RESULT_W        = 10;
	localparam int          BYTE_W          = 8;
	localparam int          CHAN_W          = 3;
	localparam int          CLK_PERIOD_NS   = 8;
	localparam int          CONV_ANALOG_NS  = 9000;
	localparam int          CONV_TEMP_NS    = 27000;
	localparam int          CNT_W           = 12;
	localparam logic [11:0] CONV_ANALOG_CYC = 12'(CONV_ANALOG_NS / CLK_PERIOD_NS);
	localparam logic [11:0] CONV_TEMP_CYC   = 12'(CONV_TEMP_NS / CLK_PERIOD_NS);
	localparam logic [2:0]  WR_LAST_BIT     = 3'h7;

	// ----------------------------------------------------------------
	// channel codes and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0]  CHAN_TEMP       = 3'h0;
	localparam logic [2:0]  CHAN_ANALOG     = 3'h1;
	localparam logic [2:0]  CHAN_BANDGAP    = 3'h7;
	localparam logic [2:0]  CHAN_RESET      = CHAN_TEMP;
	localparam logic [7:0]  THRESH_RESET    = 8'h99;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  OFS_STATUS      = 8'h00;
	localparam logic [7:0]  OFS_MASK        = 8'h04;
	localparam logic [7:0]  OFS_STATE       = 8'h08;
	localparam logic [7:0]  OFS_RESULT      = 8'h0C;
	localparam int          EV_W            = 3;
	localparam int          EV_CONV_DONE    = 0;
	localparam int          EV_OVER_TEMP    = 1;
	localparam int          EV_CTRL_WRITE   = 2;
	localparam logic [2:0]  MASK_RESET      = 3'h0;
	localparam int          ST_CHAN_LSB     = 0;
	localparam int          ST_BUSY         = 4;
	localparam int          ST_HOLD         = 5;
	localparam int          ST_PDOWN        = 6;
	localparam int          ST_FLAG_N       = 7;
	localparam int          ST_THRESH_LSB   = 8;

	typedef enum logic {TACSC_IDLE, TACSC_CONVERT} tacsc_state_e;
endpackage

/* verilog/tacsc_ctrl.sv */
// digital control of a temperature-sensing 10-bit converter with a serial port
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
module tacsc_ctrl (
	// clock and reset
	input  wire logic                          mclk_i,
	input  wire logic                          rst_n_i,
	// conversion pins
	input  wire logic                          conversion_start_n_i,
	output logic                               busy_o,
	output logic                               over_temp_flag_n_o,
	// serial pins
	input  wire logic                          sclk_i,
	input  wire logic                          rd_wr_i,
	input  wire logic                          sdata_i,
	output logic                               sdata_o,
	output logic                               sdata_oe_o,
	// analog core
	input  wire logic [tacsc_pkg::RESULT_W-1:0] adc_result_i,
	output logic      [tacsc_pkg::CHAN_W-1:0]   channel_o,
	output logic                               hold_o,
	output logic                               power_down_o,
	// register port
	input  wire logic [tacsc_pkg::ADDR_W-1:0]   reg_addr_i,
	input  wire logic [31:0]                    reg_wdata_i,
	input  wire logic                          reg_wr_i,
	input  wire logic                          reg_rd_i,
	output logic      [31:0]                    reg_rdata_o,
	// interrupt
	output logic                               irq_o
);
	import tacsc_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers: conv start, rd/wr, sclk, data
	// ----------------------------------------------------------------
	logic [3:0]            sync1;
	logic [3:0]            sync2;
	logic [3:0]            sync_prev;
	logic                  start_fall;
	logic                  rdwr_rise;
	logic                  sclk_rise;
	logic                  sclk_fall;
	logic                  rd_mode;
	logic                  sdata_s;

	// reset to each pin's idle level: start and sclk high, rd/wr low, so that
	// no false edge follows reset and the data pin is not driven after it
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1     <= 4'h5;
			sync2     <= 4'h5;
			sync_prev <= 4'h5;
		end else begin
			sync1     <= {sdata_i, sclk_i, rd_wr_i, conversion_start_n_i};
			sync2     <= sync1;
			sync_prev <= sync2;
		end
	end

	assign start_fall = sync_prev[0] & ~sync2[0];
	assign rdwr_rise  = ~sync_prev[1] & sync2[1];
	assign sclk_rise  = ~sync_prev[2] & sync2[2];
	assign sclk_fall  = sync_prev[2] & ~sync2[2];
	assign rd_mode    = sync2[1];
	assign sdata_s    = sync2[3];

	// ----------------------------------------------------------------
	// conversion sequencer
	// ----------------------------------------------------------------
	tacsc_state_e          state;
	logic [CNT_W-1:0]      conv_cnt;
	logic [CHAN_W-1:0]     conv_chan;
	logic [RESULT_W-1:0]   result;
	logic [BYTE_W-1:0]     threshold;
	logic                  conv_end;
	logic                  temp_end;
	logic                  over_temp;

	assign conv_end  = (state == TACSC_CONVERT) && (conv_cnt == '0);
	assign temp_end  = conv_end && (conv_chan == CHAN_TEMP);
	assign over_temp = adc_result_i[RESULT_W-1 -: BYTE_W] > threshold;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state     <= TACSC_IDLE;
			conv_cnt  <= '0;
			conv_chan <= CHAN_RESET;
			busy_o    <= 1'b0;
			hold_o    <= 1'b0;
		end else begin
			case (state)
				TACSC_IDLE: begin
					if (start_fall) begin
						state     <= TACSC_CONVERT;
						conv_chan <= channel_o;
						busy_o    <= 1'b1;
						hold_o    <= 1'b1;
						conv_cnt  <= (channel_o == CHAN_TEMP) ? CONV_TEMP_CYC - 12'h001
							: CONV_ANALOG_CYC - 12'h001;
					end
				end
				TACSC_CONVERT: begin
					if (conv_end) begin
						state  <= TACSC_IDLE;
						busy_o <= 1'b0;
						hold_o <= 1'b0;
					end else begin
						conv_cnt <= conv_cnt - 12'h001;
					end
				end
				default: state <= TACSC_IDLE;
			endcase
		end
	end

	// result capture and power-down decision at end of conversion
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			result       <= '0;
			power_down_o <= 1'b0;
		end else if (conv_end) begin
			result       <= adc_result_i;
			power_down_o <= ~sync2[0];
		end else if (start_fall) begin
			power_down_o <= 1'b0;
		end
	end

	// over-temperature flag: a comparison in the clearing cycle wins
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			over_temp_flag_n_o <= 1'b1;
		end else if (temp_end) begin
			over_temp_flag_n_o <= ~over_temp;
		end else if (rdwr_rise) begin
			over_temp_flag_n_o <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// serial port
	// ----------------------------------------------------------------
	logic [RESULT_W-1:0]   rd_shift;
	logic [BYTE_W-1:0]     wr_shift;
	logic [2:0]            wr_cnt;
	logic [BYTE_W-1:0]     wr_byte;
	logic                  wr_done;

	assign wr_byte = {wr_shift[BYTE_W-2:0], sdata_s};
	assign wr_done = ~rd_mode && sclk_rise && (wr_cnt == WR_LAST_BIT);

	// read path: load on read select, shift on falling clock
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_shift   <= '0;
			sdata_o    <= 1'b0;
			sdata_oe_o <= 1'b0;
		end else begin
			sdata_oe_o <= rd_mode;
			if (rdwr_rise) begin
				sdata_o  <= result[RESULT_W-1];
				rd_shift <= {result[RESULT_W-2:0], 1'b0};
			end else if (rd_mode && sclk_fall) begin
				sdata_o  <= rd_shift[RESULT_W-1];
				rd_shift <= {rd_shift[RESULT_W-2:0], 1'b0};
			end
		end
	end

	// write path: msb first, count of eight rising edges
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_shift <= '0;
			wr_cnt   <= '0;
		end else if (rd_mode) begin
			wr_cnt <= '0;
		end else if (sclk_rise) begin
			wr_shift <= wr_byte;
			wr_cnt   <= wr_cnt + 3'h1;
		end
	end

	// control byte decode
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			channel_o <= CHAN_RESET;
			threshold <= THRESH_RESET;
		end else if (wr_done) begin
			if (wr_byte[BYTE_W-1:CHAN_W] == '0) begin
				channel_o <= wr_byte[CHAN_W-1:0];
			end else begin
				threshold <= wr_byte;
			end
		end
	end

	// ----------------------------------------------------------------
	// events, interrupt and register port
	// ----------------------------------------------------------------
	logic [EV_W-1:0]       status;
	logic [EV_W-1:0]       mask;
	logic [EV_W-1:0]       events;
	logic [EV_W-1:0]       w1c;

	assign events = {wr_done, temp_end & over_temp, conv_end};
	assign w1c    = (reg_wr_i && reg_addr_i == OFS_STATUS) ? reg_wdata_i[EV_W-1:0] : '0;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status <= '0;
			mask   <= MASK_RESET;
			irq_o  <= 1'b0;
		end else begin
			status <= (status & ~w1c) | events;
			irq_o  <= |(status & mask);
			if (reg_wr_i && reg_addr_i == OFS_MASK) begin
				mask <= reg_wdata_i[EV_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= '0;
			if (reg_rd_i) begin
				case (reg_addr_i)
					OFS_STATUS: reg_rdata_o <= 32'(status);
					OFS_MASK:   reg_rdata_o <= 32'(mask);
					OFS_STATE:  reg_rdata_o <= 32'({threshold, over_temp_flag_n_o,
						power_down_o, hold_o, busy_o, 1'b0, channel_o});
					OFS_RESULT: reg_rdata_o <= 32'(result);
					default:    reg_rdata_o <= '0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	logic [CNT_W-1:0]      busy_len;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_len <= '0;
		end else begin
			busy_len <= busy_o ? busy_len + 12'h001 : '0;
		end
	end

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_start_busy: assert property (start_fall && !busy_o |=> busy_o && hold_o)
		else $error("conversion did not start on start falling edge");
	a_hold_track: assert property ($fell(busy_o) |-> !hold_o && $past(hold_o))
		else $error("track/hold not back in track at end of conversion");
	a_pdown_end: assert property (conv_end |=> power_down_o == !$past(sync2[0]))
		else $error("power-down does not follow start level at end");
	a_flag_low: assert property (temp_end && over_temp |=> !over_temp_flag_n_o)
		else $error("over-temperature flag not driven low");
	a_flag_clear: assert property (rdwr_rise && !temp_end |=> over_temp_flag_n_o)
		else $error("over-temperature flag not released on read");
	a_oe_read: assert property (sdata_oe_o |-> $past(rd_mode))
		else $error("data pin driven outside a read");
	a_shift_fall: assert property (rd_mode && sclk_fall && !rdwr_rise
		|=> sdata_o == $past(rd_shift[RESULT_W-1]))
		else $error("read bit not shifted on falling clock");
	a_chan_load: assert property (wr_done && wr_byte[7:3] == 5'h00
		|=> channel_o == $past(wr_byte[2:0]))
		else $error("channel select not loaded");
	a_thr_load: assert property (wr_done && wr_byte[7:3] != 5'h00
		|=> threshold == $past(wr_byte))
		else $error("threshold not loaded");
	a_busy_time: assert property ($fell(busy_o) |-> busy_len ==
		(($past(conv_chan) == CHAN_TEMP) ? CONV_TEMP_CYC : CONV_ANALOG_CYC))
		else $error("busy width wrong for channel");
	a_release_pin: assert property (!rd_mode |=> !sdata_oe_o)
		else $error("data pin not released");
	a_eight_bits: assert property (wr_done |-> wr_cnt == WR_LAST_BIT && !rd_mode)
		else $error("control byte acted on early");

	c_temp_conv: cover property (temp_end && over_temp);
	c_pdown:     cover property (conv_end && !sync2[0]);
	c_write:     cover property (wr_done);
	c_irq:       cover property ($rose(irq_o));
endmodule

/* verif/tacsc_host_model.sv */
// host controller model driving the conversion and serial pins
`timescale 1ns/100ps
module tacsc_host_model (
	// clock
	input  wire logic mclk_i,
	// device side of the data pin
	input  wire logic dev_data_i,
	input  wire logic dev_oe_i,
	// pins driven by the host
	output logic      start_n_o,
	output logic      sclk_o,
	output logic      rd_wr_o,
	output logic      pin_o
);
	logic host_oe  = 1'b0;
	logic host_bit = 1'b0;
	logic idle_bit = 1'b0;

	initial begin
		start_n_o = 1'b1;
		sclk_o = 1'b1;
		rd_wr_o = 1'b0;
	end

	// an undriven pin toggles so stale data never passes for valid data
	always @(posedge mclk_i) idle_bit <= ~idle_bit;
	assign pin_o = dev_oe_i ? dev_data_i : (host_oe ? host_bit : idle_bit);

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic set_start(input logic lvl);
		@(posedge mclk_i);
		start_n_o <= lvl;
	endtask

	// eight clocks, msb first, data changed while the clock is low
	task automatic write_byte(input logic [7:0] b);
		@(posedge mclk_i);
		rd_wr_o <= 1'b0;
		host_oe <= 1'b1;
		for (int i = 7; i >= 0; i--) begin
			sclk_o <= 1'b0;
			host_bit <= b[i];
			wait_cyc(4);
			sclk_o <= 1'b1;
			wait_cyc(4);
		end
		host_oe <= 1'b0;
	endtask

	// ten bits, first bit already out before the first clock
	task automatic read_word(output logic [9:0] d, output logic oe_ok);
		@(posedge mclk_i);
		sclk_o <= 1'b0;
		wait_cyc(4);
		rd_wr_o <= 1'b1;
		wait_cyc(8);
		oe_ok = 1'b1;
		for (int i = 9; i >= 0; i--) begin
			sclk_o <= 1'b1;
			wait_cyc(2);
			d[i] = pin_o;
			oe_ok = oe_ok & (dev_oe_i === 1'b1);
			wait_cyc(2);
			sclk_o <= 1'b0;
			wait_cyc(4);
		end
		rd_wr_o <= 1'b0;
	endtask
endmodule

/* verif/tacsc_ctrl_tb.sv */
// self-checking bench for the converter serial control block
`timescale 1ns/100ps
module tacsc_ctrl_tb;
	import tacsc_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic                mclk_i = 1'b0;
	logic                rst_n_i = 1'b0;
	logic                start_n, busy, flag_n, sclk, rd_wr, pin, dout, doe;
	logic                hold, power_down, irq, oe_ok;
	logic [RESULT_W-1:0] adc_result = '0;
	logic [RESULT_W-1:0] word;
	logic [CHAN_W-1:0]   channel;
	logic [ADDR_W-1:0]   reg_addr = '0;
	logic [31:0]         reg_wdata = '0;
	logic                reg_wr = 1'b0;
	logic                reg_rd = 1'b0;
	logic [31:0]         reg_rdata, rd;
	int                  errors = 0;
	int                  samples_checked = 0;
	logic [2:0]          chans [3] = '{CHAN_ANALOG, CHAN_BANDGAP, CHAN_TEMP};

	always #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;

	tacsc_ctrl dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .conversion_start_n_i(start_n),
		.busy_o(busy), .over_temp_flag_n_o(flag_n), .sclk_i(sclk), .rd_wr_i(rd_wr),
		.sdata_i(pin), .sdata_o(dout), .sdata_oe_o(doe), .adc_result_i(adc_result),
		.channel_o(channel), .hold_o(hold), .power_down_o(power_down),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .irq_o(irq));

	tacsc_host_model host (.mclk_i(mclk_i), .dev_data_i(dout), .dev_oe_i(doe),
		.start_n_o(start_n), .sclk_o(sclk), .rd_wr_o(rd_wr), .pin_o(pin));

	// ------------------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------------------
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk_i);
		reg_wr <= 1'b0;
	endtask

	task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk_i);
		reg_rd <= 1'b0;
		#1;
		rd = reg_rdata;
		check(rd, exp);
	endtask

	// one conversion; busy length is measured in clock periods
	task automatic convert(input logic [9:0] res, input logic keep_low, input logic [11:0] cyc);
		time t0;
		int  n;
		n = 0;
		@(posedge mclk_i);
		adc_result <= res;
		host.set_start(1'b0);
		while (busy !== 1'b1 && n < 40) begin
			settle(1);
			n++;
		end
		if (busy !== 1'b1) begin
			errors++;
			results();
		end
		t0 = $time;
		if (!keep_low) host.set_start(1'b1);
		while (busy === 1'b1 && n < 5000) begin
			check(32'(hold), 32'h1);
			settle(1);
			n++;
		end
		if (n >= 5000) begin
			errors++;
			results();
		end
		check(32'(($time - t0) / CLK_PERIOD_NS), 32'(cyc));
		check(32'(hold), 32'h0);
		check(32'(power_down), 32'(keep_low));
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (4) begin
			settle(1);
			check(32'(doe), 32'h0);
		end
		check(32'({busy, hold, power_down, doe, irq}), 32'h0);
		check(32'({flag_n, channel}), 32'({1'b1, CHAN_RESET}));
		check_reg(OFS_STATE, 32'h80 | (32'(THRESH_RESET) << ST_THRESH_LSB));
		check_reg(OFS_MASK, 32'h0);
		check_reg(8'h10, 32'h0);
		foreach (chans[k]) begin
			host.write_byte({5'h00, chans[k]});
			settle(8);
			check(32'(doe), 32'h0);
			check(32'(channel), 32'(chans[k]));
			convert(10'h264, 1'b0, chans[k] == CHAN_TEMP ? CONV_TEMP_CYC : CONV_ANALOG_CYC);
			check(32'(flag_n), 32'h1);
		end
		host.write_byte(8'h98);
		settle(8);
		check(32'(channel), 32'(CHAN_TEMP));
		check_reg(OFS_STATE, 32'h80 | (32'h98 << ST_THRESH_LSB));
		convert(10'h264, 1'b1, CONV_TEMP_CYC);
		check(32'(flag_n), 32'h0);
		check_reg(OFS_STATUS, 32'h7);
		check(32'(irq), 32'h0);
		reg_write(OFS_MASK, 32'h2);
		settle(2);
		check(32'(irq), 32'h1);
		reg_write(OFS_STATUS, 32'h2);
		settle(2);
		check(32'(irq), 32'h0);
		check_reg(OFS_STATUS, 32'h5);
		host.read_word(word, oe_ok);
		check(32'(word), 32'h264);
		check(32'(oe_ok), 32'h1);
		check(32'(flag_n), 32'h1);
		settle(6);
		check(32'(doe), 32'h0);
		host.set_start(1'b1);
		settle(4);
		convert(10'h3FF, 1'b0, CONV_TEMP_CYC);
		check(32'(flag_n), 32'h0);
		check_reg(OFS_RESULT, 32'h3FF);
		results();
	end
endmodule
